/* File: verilog/fsss_host.sv */
// Host controller that drives a parallel flash through its pins to
// program, lock and read the security store and to poll op status.
// Assumes software reaches it over a simple strobe port on SYS_CLK.
//
// What this block does
// - User half is programmed only by the four-cycle store command.
// - Lock command drives lock flag bit low in its fourth cycle.
// - Host issues identification exit after lock-status or store reads.
// - One write of 98h at 55h enters query-table mode.
// - Identification exit leaves query mode back to normal read.
// - After fault bit seen, poll bit is read once more.
// - After fault bit seen, toggle bit is checked once more.
`timescale 1ns/1ps

module fsss_host #(
   parameter int PON_CYCLES = fsss_pkg::PON_CYCLES_DFLT
)
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic [19:0] FLASH_ADDR,
   output logic [15:0] FLASH_DQ_OUT,
   output logic FLASH_DQ_OE_N,
   input wire logic [15:0] FLASH_DQ_IN,
   output logic FLASH_CE_N,
   output logic FLASH_OE_N,
   output logic FLASH_WE_N,
   output logic FLASH_RESET_N,
   input wire logic FLASH_RDY_BUSY
);

   typedef enum logic [2:0] {
      S_POR, S_IDLE, S_LOAD, S_SETUP, S_STROBE, S_RECOVER, S_WAIT_RDY
   } fsss_state_type;

   logic [15:0] dq_sync;
   logic rdy_sync;

   // Software registers
   logic [19:0] taddr_ff, nxt_taddr;
   logic [15:0] tdata_ff, nxt_tdata;
   logic [2:0] cfg_ff, nxt_cfg;
   logic [31:0] rdata_ff, nxt_rdata;
   logic start;

   // Sequencer state
   fsss_state_type state_ff, nxt_state;
   logic [19:0] por_ff, nxt_por;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [2:0] op_ff, nxt_op;
   logic [2:0] idx_ff, nxt_idx;
   logic cur_rd_ff, nxt_cur_rd;
   logic poll_ff, nxt_poll;
   logic exit_ff, nxt_exit;
   logic recheck_ff, nxt_recheck;
   logic have_prev_ff, nxt_have_prev;
   logic prev_tog_ff, nxt_prev_tog;
   logic [15:0] rd_ff, nxt_rd;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;
   logic fault_ff, nxt_fault;
   logic vpp_ff, nxt_vpp;
   logic locked_ff, nxt_locked;
   logic query_ff, nxt_query;

   // Pin registers
   logic [19:0] addr_ff, nxt_addr;
   logic [15:0] dq_out_ff, nxt_dq_out;
   logic dq_oe_n_ff, nxt_dq_oe_n;
   logic ce_n_ff, nxt_ce_n;
   logic oe_n_ff, nxt_oe_n;
   logic we_n_ff, nxt_we_n;
   logic frst_n_ff, nxt_frst_n;

   // ==========================================================
   // Pin input synchronisers
   fsss_sync #(.WIDTH(16)) u_dq_sync (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .d(FLASH_DQ_IN),
      .q(dq_sync)
   );

   // completion pin sampled only after two flops
   fsss_sync #(.WIDTH(1)) u_rdy_sync (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .d(FLASH_RDY_BUSY),
      .q(rdy_sync)
   );

   // ==========================================================
   // Command sequences: {kind, address, data} per step
   function automatic logic [37:0] step_of(
      input logic [2:0] op,
      input logic [2:0] idx,
      input logic [19:0] ta,
      input logic [15:0] td
   );
      logic [37:0] s;
      s = {fsss_pkg::KIND_END, fsss_pkg::ANY_ADDR, 16'h0000};
      if (op == fsss_pkg::OP_READ)
      begin
         if (idx == 3'h0)
            s = {fsss_pkg::KIND_RD, ta, 16'h0000};
      end
      else if (op == fsss_pkg::OP_QUERY)
      begin
         // single-cycle query entry, valid from any mode
         if (idx == 3'h0)
            s = {fsss_pkg::KIND_WR, fsss_pkg::QUERY_ADDR,
                 fsss_pkg::CMD_QUERY};
      end
      else if (op == fsss_pkg::OP_EXIT)
      begin
         if (idx == 3'h0)
            s = {fsss_pkg::KIND_WR, fsss_pkg::ANY_ADDR,
                 fsss_pkg::CMD_ID_EXIT};
      end
      else if (op == fsss_pkg::OP_POLL)
      begin
         if (idx == 3'h0)
            s = {fsss_pkg::KIND_POLL, ta, 16'h0000};
      end
      else
      begin
         case (idx)
            3'h0: s = {fsss_pkg::KIND_WR, fsss_pkg::UNLK_ADDR1,
                       fsss_pkg::UNLK_DATA1};
            3'h1: s = {fsss_pkg::KIND_WR, fsss_pkg::UNLK_ADDR2,
                       fsss_pkg::UNLK_DATA2};
            3'h2:
            begin
               if (op == fsss_pkg::OP_PROG_USER ||
                   op == fsss_pkg::OP_LOCK_USER)
                  s = {fsss_pkg::KIND_WR, fsss_pkg::UNLK_ADDR1,
                       fsss_pkg::CMD_STORE};
               else
                  s = {fsss_pkg::KIND_WR, fsss_pkg::UNLK_ADDR1,
                       fsss_pkg::CMD_ID_ENTRY};
            end
            3'h3:
            begin
               // user half written only as fourth store cycle
               if (op == fsss_pkg::OP_PROG_USER)
                  s = {fsss_pkg::KIND_WR, ta, td};
               // lock cycle carries lock flag bit low
               else if (op == fsss_pkg::OP_LOCK_USER)
                  s = {fsss_pkg::KIND_WR, fsss_pkg::LOCK_ADDR,
                       fsss_pkg::LOCK_DATA};
               else if (op == fsss_pkg::OP_LOCK_STAT)
                  s = {fsss_pkg::KIND_RD, fsss_pkg::LOCK_ADDR, 16'h0000};
               // store word read in identification mode
               else
                  s = {fsss_pkg::KIND_RD, ta, 16'h0000};
            end
            3'h4:
            begin
               if (op == fsss_pkg::OP_PROG_USER ||
                   op == fsss_pkg::OP_LOCK_USER)
                  s = {fsss_pkg::KIND_POLL, ta, 16'h0000};
               // leave identification mode before anything else
               else
                  s = {fsss_pkg::KIND_WR, fsss_pkg::ANY_ADDR,
                       fsss_pkg::CMD_ID_EXIT};
            end
            default: s = {fsss_pkg::KIND_END, fsss_pkg::ANY_ADDR,
                          16'h0000};
         endcase
      end
      return s;
   endfunction

   // ==========================================================
   // Software register port
   always_comb
   begin
      nxt_taddr = taddr_ff;
      nxt_tdata = tdata_ff;
      nxt_cfg = cfg_ff;
      nxt_rdata = 32'h00000000;
      start = 1'b0;
      if (REG_WR)
      begin
         // Orders arriving while busy are dropped
         if (REG_ADDR == fsss_pkg::REG_CTRL)
            start = (state_ff == S_IDLE);
         else if (REG_ADDR == fsss_pkg::REG_TADDR && !busy_ff)
            nxt_taddr = REG_WDATA[19:0];
         else if (REG_ADDR == fsss_pkg::REG_TDATA && !busy_ff)
            nxt_tdata = REG_WDATA[15:0];
         else if (REG_ADDR == fsss_pkg::REG_CFG && !busy_ff)
            nxt_cfg = REG_WDATA[2:0];
      end
      if (REG_RD)
      begin
         if (REG_ADDR == fsss_pkg::REG_TADDR)
            nxt_rdata = {12'h000, taddr_ff};
         else if (REG_ADDR == fsss_pkg::REG_TDATA)
            nxt_rdata = {16'h0000, tdata_ff};
         else if (REG_ADDR == fsss_pkg::REG_CFG)
            nxt_rdata = {29'h0, cfg_ff};
         else if (REG_ADDR == fsss_pkg::REG_STATUS)
            nxt_rdata = {25'h0, rdy_sync, query_ff, locked_ff,
                         vpp_ff, fault_ff, done_ff, busy_ff};
         else if (REG_ADDR == fsss_pkg::REG_RDATA)
            nxt_rdata = {16'h0000, rd_ff};
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         taddr_ff <= 20'h00000;
         tdata_ff <= 16'h0000;
         // device config assumed 00 after power-up
         cfg_ff <= fsss_pkg::CFG_RESET;
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         taddr_ff <= nxt_taddr;
         tdata_ff <= nxt_tdata;
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   // ==========================================================
   // Bus sequencer
   always_comb
   begin
      logic [37:0] s;
      logic [1:0] meth;
      logic hit;
      logic flt;
      s = step_of(op_ff, idx_ff, taddr_ff, tdata_ff);
      meth = cfg_ff[fsss_pkg::CFG_METHOD_LSB +: 2];
      hit = 1'b0;
      flt = rd_ff[fsss_pkg::FAULT_BIT] | rd_ff[fsss_pkg::HV_BIT];
      nxt_state = state_ff;
      nxt_por = por_ff;
      nxt_cnt = cnt_ff;
      nxt_op = op_ff;
      nxt_idx = idx_ff;
      nxt_cur_rd = cur_rd_ff;
      nxt_poll = poll_ff;
      nxt_exit = exit_ff;
      nxt_recheck = recheck_ff;
      nxt_have_prev = have_prev_ff;
      nxt_prev_tog = prev_tog_ff;
      nxt_rd = rd_ff;
      nxt_busy = busy_ff;
      nxt_done = done_ff;
      nxt_fault = fault_ff;
      nxt_vpp = vpp_ff;
      nxt_locked = locked_ff;
      nxt_query = query_ff;
      nxt_addr = addr_ff;
      nxt_dq_out = dq_out_ff;
      nxt_dq_oe_n = dq_oe_n_ff;
      nxt_ce_n = ce_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_we_n = we_n_ff;
      nxt_frst_n = frst_n_ff;
      case (state_ff)
         S_POR:
         begin
            // pulse flash reset so no mode survives
            nxt_por = por_ff + 20'h00001;
            if (por_ff == 20'(fsss_pkg::RST_CYCLES))
               nxt_frst_n = 1'b1;
            if (por_ff == 20'(PON_CYCLES))
            begin
               nxt_busy = 1'b0;
               nxt_state = S_IDLE;
            end
         end
         S_IDLE:
         begin
            if (start)
            begin
               nxt_op = REG_WDATA[2:0];
               nxt_idx = 3'h0;
               nxt_busy = 1'b1;
               nxt_done = 1'b0;
               nxt_fault = 1'b0;
               nxt_vpp = 1'b0;
               nxt_exit = 1'b0;
               nxt_poll = 1'b0;
               nxt_recheck = 1'b0;
               nxt_have_prev = 1'b0;
               nxt_state = S_LOAD;
            end
         end
         S_LOAD:
         begin
            if (exit_ff)
            begin
               // Fault leaves device in status mode; exit back to read
               nxt_cur_rd = 1'b0;
               nxt_addr = fsss_pkg::ANY_ADDR;
               nxt_dq_out = fsss_pkg::CMD_ID_EXIT;
               nxt_state = S_SETUP;
            end
            else if (s[37:36] == fsss_pkg::KIND_END)
            begin
               if (op_ff == fsss_pkg::OP_QUERY)
                  nxt_query = 1'b1;
               else if (op_ff == fsss_pkg::OP_EXIT)
                  nxt_query = 1'b0;
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_state = S_IDLE;
            end
            else if (s[37:36] == fsss_pkg::KIND_POLL)
            begin
               nxt_poll = 1'b1;
               nxt_cur_rd = 1'b1;
               nxt_addr = s[35:16];
               // wait for released completion line first
               if (meth == fsss_pkg::METH_RDY)
                  nxt_state = S_WAIT_RDY;
               else
                  nxt_state = S_SETUP;
            end
            else
            begin
               nxt_cur_rd = (s[37:36] == fsss_pkg::KIND_RD);
               nxt_addr = s[35:16];
               if (s[37:36] == fsss_pkg::KIND_WR)
                  nxt_dq_out = s[15:0];
               nxt_state = S_SETUP;
            end
         end
         S_WAIT_RDY:
         begin
            if (rdy_sync)
               nxt_state = S_SETUP;
         end
         S_SETUP:
         begin
            nxt_ce_n = 1'b0;
            nxt_dq_oe_n = cur_rd_ff;
            // output enable held high on writes
            if (cur_rd_ff)
            begin
               nxt_oe_n = 1'b0;
               nxt_cnt = 4'(fsss_pkg::RD_CYCLES - 1);
            end
            else
            begin
               nxt_we_n = 1'b0;
               nxt_cnt = 4'(fsss_pkg::WE_CYCLES - 1);
            end
            nxt_state = S_STROBE;
         end
         S_STROBE:
         begin
            if (cnt_ff == 4'h0)
            begin
               if (cur_rd_ff)
                  nxt_rd = dq_sync;
               nxt_oe_n = 1'b1;
               nxt_we_n = 1'b1;
               nxt_state = S_RECOVER;
            end
            else
               nxt_cnt = cnt_ff - 4'h1;
         end
         S_RECOVER:
         begin
            nxt_ce_n = 1'b1;
            nxt_dq_oe_n = 1'b1;
            nxt_state = S_LOAD;
            if (exit_ff)
            begin
               nxt_exit = 1'b0;
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_state = S_IDLE;
            end
            else if (poll_ff)
            begin
               // toggle method compares two successive reads
               if (meth == fsss_pkg::METH_TOGGLE)
                  hit = have_prev_ff &&
                        (rd_ff[fsss_pkg::TOGGLE_BIT] == prev_tog_ff);
               // config 00 compares with loaded data
               else if (!cfg_ff[fsss_pkg::CFG_DEV01])
                  hit = rd_ff[fsss_pkg::POLL_BIT] ==
                        dq_out_ff[fsss_pkg::POLL_BIT];
               // config 01 done only when poll bit high
               else
                  hit = rd_ff[fsss_pkg::POLL_BIT];
               nxt_have_prev = 1'b1;
               nxt_prev_tog = rd_ff[fsss_pkg::TOGGLE_BIT];
               if (hit)
               begin
                  nxt_poll = 1'b0;
                  nxt_idx = idx_ff + 3'h1;
               end
               // one more look after a fault flag
               else if (flt && !recheck_ff)
               begin
                  nxt_recheck = 1'b1;
                  nxt_state = S_SETUP;
               end
               // report fault and leave status mode
               else if (flt)
               begin
                  nxt_fault = rd_ff[fsss_pkg::FAULT_BIT];
                  nxt_vpp = rd_ff[fsss_pkg::HV_BIT];
                  nxt_poll = 1'b0;
                  nxt_exit = 1'b1;
               end
               else
                  nxt_state = S_SETUP;
            end
            else
            begin
               // lock flag low means user half locked
               if (op_ff == fsss_pkg::OP_LOCK_STAT && cur_rd_ff)
                  nxt_locked = ~rd_ff[fsss_pkg::LOCK_FLAG_BIT];
               nxt_idx = idx_ff + 3'h1;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         state_ff <= S_POR;
         por_ff <= 20'h00000;
         cnt_ff <= 4'h0;
         op_ff <= fsss_pkg::OP_READ;
         idx_ff <= 3'h0;
         cur_rd_ff <= 1'b0;
         poll_ff <= 1'b0;
         exit_ff <= 1'b0;
         recheck_ff <= 1'b0;
         have_prev_ff <= 1'b0;
         prev_tog_ff <= 1'b0;
         rd_ff <= 16'h0000;
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
         fault_ff <= 1'b0;
         vpp_ff <= 1'b0;
         locked_ff <= 1'b0;
         query_ff <= 1'b0;
         addr_ff <= 20'h00000;
         dq_out_ff <= 16'h0000;
         dq_oe_n_ff <= 1'b1;
         ce_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         frst_n_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         por_ff <= nxt_por;
         cnt_ff <= nxt_cnt;
         op_ff <= nxt_op;
         idx_ff <= nxt_idx;
         cur_rd_ff <= nxt_cur_rd;
         poll_ff <= nxt_poll;
         exit_ff <= nxt_exit;
         recheck_ff <= nxt_recheck;
         have_prev_ff <= nxt_have_prev;
         prev_tog_ff <= nxt_prev_tog;
         rd_ff <= nxt_rd;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         fault_ff <= nxt_fault;
         vpp_ff <= nxt_vpp;
         locked_ff <= nxt_locked;
         query_ff <= nxt_query;
         addr_ff <= nxt_addr;
         dq_out_ff <= nxt_dq_out;
         dq_oe_n_ff <= nxt_dq_oe_n;
         ce_n_ff <= nxt_ce_n;
         oe_n_ff <= nxt_oe_n;
         we_n_ff <= nxt_we_n;
         frst_n_ff <= nxt_frst_n;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign FLASH_ADDR = addr_ff;
   assign FLASH_DQ_OUT = dq_out_ff;
   assign FLASH_DQ_OE_N = dq_oe_n_ff;
   assign FLASH_CE_N = ce_n_ff;
   assign FLASH_OE_N = oe_n_ff;
   assign FLASH_WE_N = we_n_ff;
   assign FLASH_RESET_N = frst_n_ff;

endmodule // fsss_host

/* File: shared/fsss_pkg.sv */
// Constants for the host-side security-store and status controller.
// Assumes a 50 MHz system clock and a 16-bit parallel flash on the pins.
package fsss_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_WE_NS = 60;
   localparam int T_RD_NS = 100;
   localparam int T_RST_PULSE_NS = 600;
   localparam int T_PON_MS = 10;
   localparam int SYNC_STAGES = 2;
   localparam int WE_CYCLES = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Read strobe also covers the input synchroniser latency
   localparam int RD_CYCLES =
      (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   localparam int RST_CYCLES =
      (T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PON_CYCLES_DFLT =
      (T_PON_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Software register map (byte offsets)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TADDR = 8'h04;
   localparam logic [7:0] REG_TDATA = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA = 8'h14;

   // Status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_VPP = 3;
   localparam int ST_LOCKED = 4;
   localparam int ST_QUERY = 5;
   localparam int ST_READY_PIN = 6;

   // Config register fields and reset values
   localparam int CFG_METHOD_LSB = 0;
   localparam int CFG_DEV01 = 2;
   localparam logic [1:0] METH_DATA = 2'h0;
   localparam logic [1:0] METH_TOGGLE = 2'h1;
   localparam logic [1:0] METH_RDY = 2'h2;
   localparam logic [2:0] CFG_RESET = 3'h0;

   // Operations written to the control register
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_PROG_USER = 3'h1;
   localparam logic [2:0] OP_LOCK_USER = 3'h2;
   localparam logic [2:0] OP_LOCK_STAT = 3'h3;
   localparam logic [2:0] OP_READ_STORE = 3'h4;
   localparam logic [2:0] OP_QUERY = 3'h5;
   localparam logic [2:0] OP_EXIT = 3'h6;
   localparam logic [2:0] OP_POLL = 3'h7;

   // ==========================================================
   // Flash command cycles
   localparam logic [19:0] UNLK_ADDR1 = 20'h00555;
   localparam logic [19:0] UNLK_ADDR2 = 20'h00AAA;
   localparam logic [19:0] QUERY_ADDR = 20'h00055;
   localparam logic [19:0] LOCK_ADDR = 20'h00080;
   localparam logic [19:0] ANY_ADDR = 20'h00000;
   localparam logic [15:0] UNLK_DATA1 = 16'h00AA;
   localparam logic [15:0] UNLK_DATA2 = 16'h0055;
   localparam logic [15:0] CMD_STORE = 16'h00C0;
   localparam logic [15:0] CMD_ID_ENTRY = 16'h0090;
   localparam logic [15:0] CMD_ID_EXIT = 16'h00F0;
   localparam logic [15:0] CMD_QUERY = 16'h0098;
   // Lock bit must be zero; other bits are don't care
   localparam logic [15:0] LOCK_DATA = 16'h0000;

   // Status bits on the data lines
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int FAULT_BIT = 5;
   localparam int HV_BIT = 3;
   localparam int LOCK_FLAG_BIT = 1;

   // Step kinds of a command sequence
   localparam logic [1:0] KIND_WR = 2'h0;
   localparam logic [1:0] KIND_RD = 2'h1;
   localparam logic [1:0] KIND_POLL = 2'h2;
   localparam logic [1:0] KIND_END = 2'h3;

endpackage

/* File: verilog/fsss_sync.sv */
// Two-flop synchroniser for inputs arriving from the flash pins.
// Assumes the input is asynchronous to SYS_CLK; multi-bit use only for
// values that are stable when sampled (data bus held by read strobe).
`timescale 1ns/1ps

module fsss_sync #(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // ==========================================================
   // Two stages, first stage read only by the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule // fsss_sync

/* File: verif/fsss_flash_model.sv */
// Behavioural flash: command decoder, security store, status bits.
// Assumes the bench resolves the data bus; the model drives the ready line itself.
`timescale 1ns/1ps
module fsss_flash_model
(
   input wire logic [19:0] a,
   input wire logic [15:0] d,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic rst_n,
   output logic [15:0] q = 16'h0,
   output logic rdy
);
   logic [15:0] st [4];
   logic [15:0] ld;
   logic [1:0] ph;
   logic c0, idm, lk, flt, pend, tg;
   int busy;
   assign rdy = (busy == 0);
   // Busy runs down with time so the ready line can end a wait
   always #200 if (busy > 0) busy--;
   // ==========================================================
   // Command writes
   always @(posedge we_n or negedge rst_n)
      if (!rst_n)
         {ph, c0, idm, lk, flt, pend, tg, busy} = 0;
      else if (!ce_n)
      begin
         pend = 0;
         if (c0)
         begin
            {c0, ld, pend} = {1'b0, d, 1'b1};
            if (a[7:0] == 8'h80)
               lk |= !d[1];
            else if (lk)
               flt = 1;
            else
               {st[a[1:0]], busy} = {d, 32'h3};
         end
         else if (d[7:0] == 8'hAA)
            ph = 1;
         else if (ph == 1 && d[7:0] == 8'h55)
            ph = 2;
         else if (ph == 2)
            {c0, idm, ph} = {d[7:0] == 8'hC0, idm | d[7:0] == 8'h90, 2'h0};
         else if (d[7:0] == 8'hF0)
            {idm, flt} = 0;
      end
   // ==========================================================
   // Reads
   // Look a moment later: select and enable fall in one step
   always @(negedge oe_n)
      #1 if (!ce_n)
      begin
         tg = !tg;
         if (busy > 0)
            q = {8'h0, !ld[7], tg, 6'h0};
         // fault bit up, high-voltage bit low
         else if (flt)
            q = {8'h0, !ld[7], tg, 6'h20};
         else if (pend)
            q = ld;
         else if (idm && a[7:0] == 8'h80)
            q = {14'h0, !lk, 1'b0};
         else
            q = st[a[1:0]];
      end
   // Released bus shows no stale value
   always @(posedge oe_n)
      q = ~q;
endmodule // fsss_flash_model

/* File: verif/fsss_host_asserts.sv */
// Strobe and sequencing checks on the flash pins.
// Assumes binding into fsss_host with its power-on count.
`timescale 1ns/1ps
module fsss_host_asserts #(
   parameter int PON_CYCLES = 40
)
(
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic FLASH_CE_N,
   input wire logic FLASH_OE_N,
   input wire logic FLASH_WE_N,
   input wire logic FLASH_DQ_OE_N,
   input wire logic FLASH_RESET_N
);
   int cnt_ff;
   always_ff @(posedge SYS_CLK)
      cnt_ff <= !RESET_N ? 0 : cnt_ff + int'(cnt_ff < PON_CYCLES);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence we_low;
      !FLASH_WE_N [*3] ##1 FLASH_WE_N;
   endsequence
   sequence oe_low;
      !FLASH_OE_N [*7] ##1 FLASH_OE_N;
   endsequence
   AST_WE_PULSE: assert property ($fell(FLASH_WE_N) |-> we_low)
      else $error("write strobe width");
   AST_OE_PULSE: assert property ($fell(FLASH_OE_N) |-> oe_low)
      else $error("read strobe width");
   AST_WE_OE: assert property (!FLASH_WE_N |-> FLASH_OE_N)
      else $error("write with output enable");
   AST_WE_CE: assert property (!FLASH_WE_N |-> !FLASH_CE_N)
      else $error("write without select");
   AST_CE_HOLD: assert property ($rose(FLASH_WE_N) |-> !FLASH_CE_N)
      else $error("select released with write strobe");
   AST_DRIVE: assert property (!FLASH_WE_N |-> !FLASH_DQ_OE_N)
      else $error("write data not driven");
   AST_NO_FIGHT: assert property (!FLASH_OE_N |-> FLASH_DQ_OE_N)
      else $error("bus contention");
   AST_PON: assert property (!FLASH_WE_N |-> cnt_ff >= PON_CYCLES)
      else $error("write before power-on delay");
   AST_RST_FLASH: assert property (!FLASH_WE_N |-> FLASH_RESET_N)
      else $error("write during flash reset");
endmodule // fsss_host_asserts
bind fsss_host fsss_host_asserts #(.PON_CYCLES(PON_CYCLES)) i_chk (.*);

/* File: verif/fsss_host_bench.sv */
// Self-checking bench: host controller against a flash model.
// Assumes a short power-on count so the run stays brief.
`timescale 1ns/1ps
module fsss_host_bench;
   logic SYS_CLK, RESET_N, REG_WR, REG_RD, FLASH_CE_N, FLASH_OE_N;
   logic FLASH_WE_N, FLASH_DQ_OE_N, FLASH_RESET_N, FLASH_RDY_BUSY;
   logic [7:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, v;
   logic [19:0] FLASH_ADDR;
   logic [15:0] FLASH_DQ_OUT, mq, w0;
   int bad_count, tests_run;
   wire logic [15:0] FLASH_DQ_IN = FLASH_DQ_OE_N ? mq : FLASH_DQ_OUT;
   fsss_host #(.PON_CYCLES(40)) i_fsss_host (.*);
   fsss_flash_model i_fsss_flash_model (.a(FLASH_ADDR), .d(FLASH_DQ_OUT),
      .ce_n(FLASH_CE_N), .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N),
      .rst_n(FLASH_RESET_N), .q(mq), .rdy(FLASH_RDY_BUSY));
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge SYS_CLK);
      {REG_WR, REG_RD, REG_ADDR, REG_WDATA} <= {w, !w, a, d};
      @(posedge SYS_CLK);
      {REG_WR, REG_RD} <= 2'h0;
      #1 v = REG_RDATA;
   endtask
   // Waits on busy; a hang counts as a mismatch
   task automatic run(logic [2:0] op, logic go);
      int i = 0;
      if (go)
         acc(1, fsss_pkg::REG_CTRL, {29'h0, op});
      // Always look at status at least once after a start
      do
         acc(0, fsss_pkg::REG_STATUS, 0);
      while (v[0] !== 1'b0 && ++i < 300);
      if (v[0] !== 1'b0)
      begin
         bad_count++;
         finish_test();
      end
   endtask
   initial
   begin
      SYS_CLK = 0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      {RESET_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA, v} = 0;
      {bad_count, tests_run} = 0;
      w0 = 16'($urandom(32'h44315CCF));
      repeat (12) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      acc(0, fsss_pkg::REG_STATUS, 0);
      chk("pon busy", v, 32'h1);
      run(0, 0);
      acc(0, fsss_pkg::REG_CFG, 0);
      chk("cfg", v, 0);
      acc(0, 8'hFC, 0);
      chk("unmapped", v, 0);
      // Data poll, toggle poll, then ready-pin wait
      for (int k = 0; k < 3; k++)
      begin
         w0 = 16'($urandom);
         acc(1, fsss_pkg::REG_CFG, 32'(k));
         acc(1, fsss_pkg::REG_TADDR, 32'(k));
         acc(1, fsss_pkg::REG_TDATA, {16'h0, w0});
         run(fsss_pkg::OP_PROG_USER, 1);
         chk("prog", v[2:1], 32'h1);
         run(fsss_pkg::OP_READ_STORE, 1);
         acc(0, fsss_pkg::REG_RDATA, 0);
         chk("store", v, {16'h0, w0});
      end
      run(fsss_pkg::OP_LOCK_STAT, 1);
      chk("open", v[4], 0);
      run(fsss_pkg::OP_LOCK_USER, 1);
      run(fsss_pkg::OP_LOCK_STAT, 1);
      chk("locked", v[4], 1);
      acc(1, fsss_pkg::REG_TDATA, {16'h0, ~w0});
      run(fsss_pkg::OP_PROG_USER, 1);
      chk("refused", v[2:1], 32'h3);
      chk("vpp", v[3], 0);
      run(fsss_pkg::OP_READ_STORE, 1);
      acc(0, fsss_pkg::REG_RDATA, 0);
      chk("kept", v, {16'h0, w0});
      run(fsss_pkg::OP_QUERY, 1);
      chk("query", v[5], 1);
      run(fsss_pkg::OP_EXIT, 1);
      chk("query off", v[5], 0);
      finish_test();
   end
endmodule // fsss_host_bench
